// ### common/acs_pkg.sv
package acs_pkg;

    // register port
    localparam int unsigned ADDR_W            = 4;
    localparam int unsigned DATA_W            = 16;
    localparam logic [3:0]  OFFS_CH123_SEL    = 4'h0;
    localparam logic [3:0]  OFFS_ROUTE_STATUS = 4'h1;

    // ch123_input_select field layout
    localparam int unsigned POS_SEL_A_BIT     = 0;
    localparam int unsigned NEG_SEL_A_LSB     = 1;
    localparam int unsigned POS_SEL_B_BIT     = 8;
    localparam int unsigned NEG_SEL_B_LSB     = 9;
    localparam logic [15:0] CH123_IMPL_MASK   = 16'h0707;
    localparam logic [15:0] CH123_RESET       = 16'h0000;

    // route status field layout
    localparam int unsigned STAT_SAMPLE_B_BIT = 0;
    localparam int unsigned STAT_TWELVE_BIT   = 1;
    localparam int unsigned STAT_ALT_BIT      = 2;

    // analog input numbering
    localparam int unsigned NUM_CH            = 3;
    localparam int unsigned AIN_W             = 5;
    localparam logic [4:0]  POS_BASE_LOW      = 5'h00;
    localparam logic [4:0]  POS_BASE_HIGH     = 5'h03;
    localparam logic [4:0]  NEG_BASE_LOW      = 5'h06;
    localparam logic [4:0]  NEG_BASE_HIGH     = 5'h09;
    localparam logic [4:0]  AIN_RESET         = 5'h00;
    localparam logic [14:0] POS_AIN_RESET     = 15'h0820;
    localparam logic [14:0] NEG_AIN_RESET     = 15'h0000;
    localparam logic [2:0]  NEG_VREF_RESET    = 3'h7;

    // negative select codes
    localparam logic [1:0]  NEG_CODE_HIGH     = 2'h3;
    localparam logic [1:0]  NEG_CODE_LOW      = 2'h2;

    typedef enum logic {
        ACS_SAMPLE_A,
        ACS_SAMPLE_B
    } acs_phase_e;

endpackage : acs_pkg

// ### design/acs_ch_route.sv
module acs_ch_route
    import acs_pkg::*;
(
    // selected fields
    input  wire logic                        pos_sel,
    input  wire logic [1:0]                  neg_sel,
    // per-channel analog routing
    output logic      [acs_pkg::NUM_CH*acs_pkg::AIN_W-1:0] pos_ain,
    output logic      [acs_pkg::NUM_CH*acs_pkg::AIN_W-1:0] neg_ain,
    output logic      [acs_pkg::NUM_CH-1:0]                neg_vref
);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            localparam logic [4:0] CH_OFFS = 5'(ch);

            always_comb begin
                // positive: AN3..AN5 when set, AN0..AN2 when clear
                pos_ain[ch*AIN_W +: AIN_W] = pos_sel ? (POS_BASE_HIGH + CH_OFFS)
                                                     : (POS_BASE_LOW + CH_OFFS);
                // negative: 11 -> AN9..AN11, 10 -> AN6..AN8, 0x -> vref-
                if (neg_sel == NEG_CODE_HIGH) begin
                    neg_ain[ch*AIN_W +: AIN_W] = NEG_BASE_HIGH + CH_OFFS;
                    neg_vref[ch]               = 1'b0;
                end else if (neg_sel == NEG_CODE_LOW) begin
                    neg_ain[ch*AIN_W +: AIN_W] = NEG_BASE_LOW + CH_OFFS;
                    neg_vref[ch]               = 1'b0;
                end else begin
                    neg_ain[ch*AIN_W +: AIN_W] = AIN_RESET;
                    neg_vref[ch]               = 1'b1;
                end
            end
        end
    endgenerate

endmodule : acs_ch_route

// ### design/acs_ch123_select.sv
// Design decisions made here: strobed register access and the address map.
module acs_ch123_select
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // register port
    input  wire logic [acs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [acs_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [acs_pkg::DATA_W-1:0]  reg_rdata,
    // converter control
    input  wire logic                        twelve_bit_mode,
    input  wire logic                        alternate_sample_enable,
    input  wire logic                        sample_done,
    // analog multiplexer drive
    output logic      [acs_pkg::NUM_CH*acs_pkg::AIN_W-1:0] pos_ain,
    output logic      [acs_pkg::NUM_CH*acs_pkg::AIN_W-1:0] neg_ain,
    output logic      [acs_pkg::NUM_CH-1:0]                neg_vref,
    output logic                             sample_b_active
);

    // stored fields
    logic                 pos_sel_sample_a_r;
    logic                 pos_sel_sample_a_nxt;
    logic [1:0]           neg_sel_sample_a_r;
    logic [1:0]           neg_sel_sample_a_nxt;
    logic                 pos_sel_sample_b_r;
    logic                 pos_sel_sample_b_nxt;
    logic [1:0]           neg_sel_sample_b_r;
    logic [1:0]           neg_sel_sample_b_nxt;

    // read path and sample phase
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;
    acs_phase_e           phase_r;
    acs_phase_e           phase_nxt;

    // fields as seen by hardware and software
    logic                 eff_pos_a;
    logic [1:0]           eff_neg_a;
    logic                 eff_pos_b;
    logic [1:0]           eff_neg_b;
    logic [DATA_W-1:0]    ch123_view;
    logic [DATA_W-1:0]    status_view;

    // applied selection and decoded routing
    logic                 cur_pos;
    logic [1:0]           cur_neg;
    logic [NUM_CH*AIN_W-1:0] pos_ain_nxt;
    logic [NUM_CH*AIN_W-1:0] neg_ain_nxt;
    logic [NUM_CH-1:0]       neg_vref_nxt;
    logic [NUM_CH*AIN_W-1:0] pos_ain_r;
    logic [NUM_CH*AIN_W-1:0] neg_ain_r;
    logic [NUM_CH-1:0]       neg_vref_r;

    // register port decode
    logic                 sel_wr_ch123;

    // field masking
    // stored bits are kept in twelve-bit mode but hidden, so leaving the
    // mode restores what software last wrote before entering it
    always_comb begin
        // twelve-bit mode hides the selects from software and routing alike
        if (twelve_bit_mode) begin
            eff_pos_a = 1'b0;
            eff_pos_b = 1'b0;
            eff_neg_a = 2'h0;
            eff_neg_b = 2'h0;
        end else begin
            eff_pos_a = pos_sel_sample_a_r;
            eff_pos_b = pos_sel_sample_b_r;
            eff_neg_a = neg_sel_sample_a_r;
            eff_neg_b = neg_sel_sample_b_r;
        end

        ch123_view                                     = '0;
        ch123_view[POS_SEL_A_BIT]                      = eff_pos_a;
        ch123_view[NEG_SEL_A_LSB +: 2]                 = eff_neg_a;
        ch123_view[POS_SEL_B_BIT]                      = eff_pos_b;
        ch123_view[NEG_SEL_B_LSB +: 2]                 = eff_neg_b;

        // status word is read-only and reflects the registered sample phase and the live mode inputs
        status_view                                    = '0;
        status_view[STAT_SAMPLE_B_BIT]                 = (phase_r == ACS_SAMPLE_B);
        status_view[STAT_TWELVE_BIT]                   = twelve_bit_mode;
        status_view[STAT_ALT_BIT]                      = alternate_sample_enable;
    end

    // write decode; a refused write leaves no sign on the port
    always_comb begin
        sel_wr_ch123 = reg_wr && (reg_addr == OFFS_CH123_SEL);
    end

    // register writes
    // fields change as a whole; reserved bits of the word are dropped
    always_comb begin
        pos_sel_sample_a_nxt = pos_sel_sample_a_r;
        neg_sel_sample_a_nxt = neg_sel_sample_a_r;
        pos_sel_sample_b_nxt = pos_sel_sample_b_r;
        neg_sel_sample_b_nxt = neg_sel_sample_b_r;
        if (sel_wr_ch123 && !twelve_bit_mode) begin
            pos_sel_sample_a_nxt = reg_wdata[POS_SEL_A_BIT];
            neg_sel_sample_a_nxt = reg_wdata[NEG_SEL_A_LSB +: 2];
            pos_sel_sample_b_nxt = reg_wdata[POS_SEL_B_BIT];
            neg_sel_sample_b_nxt = reg_wdata[NEG_SEL_B_LSB +: 2];
        end
    end

    // register reads; unmapped addresses return zero
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFFS_CH123_SEL:    rdata_nxt = ch123_view & CH123_IMPL_MASK;
                OFFS_ROUTE_STATUS: rdata_nxt = status_view;
                default:           rdata_nxt = '0;
            endcase
        end
    end

    // sample phase
    // dropping out of alternate mode returns to A at once, so the next
    // sample after re-enabling always starts from the A selection
    always_comb begin
        phase_nxt = phase_r;
        if (!alternate_sample_enable) begin
            phase_nxt = ACS_SAMPLE_A;
        end else if (sample_done) begin
            case (phase_r)
                ACS_SAMPLE_A: phase_nxt = ACS_SAMPLE_B;
                ACS_SAMPLE_B: phase_nxt = ACS_SAMPLE_A;
                default:      phase_nxt = ACS_SAMPLE_A;
            endcase
        end
    end

    // applied selection
    always_comb begin
        if (alternate_sample_enable && phase_r == ACS_SAMPLE_B) begin
            cur_pos = eff_pos_b;
            cur_neg = eff_neg_b;
        end else begin
            cur_pos = eff_pos_a;
            cur_neg = eff_neg_a;
        end
    end

    // one decoder serves all three channels, since they share the selects
    acs_ch_route u_route (
        .pos_sel  (cur_pos),
        .neg_sel  (cur_neg),
        .pos_ain  (pos_ain_nxt),
        .neg_ain  (neg_ain_nxt),
        .neg_vref (neg_vref_nxt)
    );

    // field flops; reset clears every implemented select
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pos_sel_sample_a_r <= CH123_RESET[POS_SEL_A_BIT];
            neg_sel_sample_a_r <= CH123_RESET[NEG_SEL_A_LSB +: 2];
            pos_sel_sample_b_r <= CH123_RESET[POS_SEL_B_BIT];
            neg_sel_sample_b_r <= CH123_RESET[NEG_SEL_B_LSB +: 2];
        end else begin
            pos_sel_sample_a_r <= pos_sel_sample_a_nxt;
            neg_sel_sample_a_r <= neg_sel_sample_a_nxt;
            pos_sel_sample_b_r <= pos_sel_sample_b_nxt;
            neg_sel_sample_b_r <= neg_sel_sample_b_nxt;
        end
    end

    // read data flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // phase flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= ACS_SAMPLE_A;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // routing flops; reset shows AN0-AN2 and vref- on every channel,
    // the same routing that cleared fields decode to, so no jump on release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pos_ain_r  <= POS_AIN_RESET;
            neg_ain_r  <= NEG_AIN_RESET;
            neg_vref_r <= NEG_VREF_RESET;
        end else begin
            pos_ain_r  <= pos_ain_nxt;
            neg_ain_r  <= neg_ain_nxt;
            neg_vref_r <= neg_vref_nxt;
        end
    end

    // outputs straight from flops; routing lags the applied selection by one cycle and a register write by two
    assign reg_rdata       = rdata_r;
    assign pos_ain         = pos_ain_r;
    assign neg_ain         = neg_ain_r;
    assign neg_vref        = neg_vref_r;
    assign sample_b_active = (phase_r == ACS_SAMPLE_B);

endmodule : acs_ch123_select

// ### test/acs_mux_model.sv
module acs_mux_model (
    // routing from the select block
    input  wire logic [14:0] pos_ain,
    input  wire logic [14:0] neg_ain,
    input  wire logic [2:0]  neg_vref,
    // analog inputs and reference in use
    output logic      [11:0] pos_used,
    output logic      [11:0] neg_used,
    output logic             vref_used
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        pos_used = 12'h000;
        neg_used = 12'h000;
        for (int ch = 0; ch < 3; ch++) begin
            pos_used[pos_ain[5*ch+:5]] = 1'b1;
            if (!neg_vref[ch])
                neg_used[neg_ain[5*ch+:5]] = 1'b1;
        end
        vref_used = |neg_vref;
    end
endmodule : acs_mux_model

// ### test/acs_ch123_select_monitor.sv
module acs_ch123_monitor (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // control and routing
    input wire logic        twelve_bit_mode,
    input wire logic        alternate_sample_enable,
    input wire logic        sample_done,
    input wire logic [14:0] pos_ain,
    input wire logic [14:0] neg_ain,
    input wire logic [2:0]  neg_vref,
    input wire logic        sample_b_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside read slot");
    a_rsvd_zero: assert property ((reg_rdata & 16'hf8f8) == 16'h0)
        else $error("reserved bits nonzero");
    a_twelve_read: assert property (reg_rd && reg_addr == 4'h0 && twelve_bit_mode |=> reg_rdata == 16'h0)
        else $error("selects visible in twelve bit mode");
    a_phase_flip: assert property (sample_done && alternate_sample_enable |=> sample_b_active != $past(sample_b_active))
        else $error("phase did not toggle");
    a_phase_force: assert property (!alternate_sample_enable |=> !sample_b_active)
        else $error("phase b without alternate");
    a_twelve_route: assert property (twelve_bit_mode [*2] |-> pos_ain == 15'h0820 && neg_vref == 3'h7)
        else $error("routing not masked");
    a_pos_map: assert property (pos_ain[4:0] inside {5'h0, 5'h3} && pos_ain[9:5] == pos_ain[4:0] + 5'h1
        && pos_ain[14:10] == pos_ain[4:0] + 5'h2) else $error("positive routing malformed");
    a_neg_map: assert property ((neg_vref == 3'h7 && neg_ain == 15'h0) || (neg_vref == 3'h0
        && neg_ain[4:0] inside {5'h6, 5'h9} && neg_ain[9:5] == neg_ain[4:0] + 5'h1
        && neg_ain[14:10] == neg_ain[4:0] + 5'h2)) else $error("negative routing malformed");
    a_write_route: assert property (reg_wr && reg_addr == 4'h0 && !twelve_bit_mode && !alternate_sample_enable
        ##1 !twelve_bit_mode |=> pos_ain[4:0] == ($past(reg_wdata[0], 2) ? 5'h3 : 5'h0))
        else $error("write not routed in two cycles");
endmodule : acs_ch123_monitor

bind acs_ch123_select acs_ch123_monitor u_mon (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .twelve_bit_mode(twelve_bit_mode), .alternate_sample_enable(alternate_sample_enable),
    .sample_done(sample_done), .pos_ain(pos_ain), .neg_ain(neg_ain), .neg_vref(neg_vref),
    .sample_b_active(sample_b_active));

// ### test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, twelve = 1'b0, alt = 1'b0, done = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, d;
    logic [14:0] pos_ain, neg_ain;
    logic [2:0]  neg_vref;
    logic        sample_b_active, vref_used;
    logic [11:0] pos_used, neg_used;
    int mismatches = 0, tests_run = 0, cycles = 0;
    always #5 mclk = ~mclk;
    acs_ch123_select u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .twelve_bit_mode(twelve),
        .alternate_sample_enable(alt), .sample_done(done), .pos_ain(pos_ain), .neg_ain(neg_ain),
        .neg_vref(neg_vref), .sample_b_active(sample_b_active));
    acs_mux_model u_mux (.pos_ain(pos_ain), .neg_ain(neg_ain), .neg_vref(neg_vref),
        .pos_used(pos_used), .neg_used(neg_used), .vref_used(vref_used));
    function automatic logic [24:0] exp_route(input logic p, input logic [1:0] n);
        return {!n[1], n == 2'h3 ? 12'he00 : n[1] ? 12'h1c0 : 12'h000, p ? 12'h038 : 12'h007};
    endfunction : exp_route
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input logic t, input logic a, input logic s);
        @(posedge mclk);
        twelve <= t;
        alt    <= a;
        done   <= s;
    endtask : step
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic route(input logic p, input logic [1:0] n);
        repeat (2) @(posedge mclk);
        #1 chk({vref_used, neg_used, pos_used}, exp_route(p, n));
    endtask : route
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        void'($urandom(88));
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd(4'h0, 16'h0);
        route(1'b0, 2'h0);
        $display("reset test done");
        // every a and b select combination, random junk in reserved bits
        for (int i = 0; i < 64; i++) begin
            d = 16'(($urandom & 16'hf8f8) | {5'h0, i[5:3], 5'h0, i[2:0]});
            step(1'b0, 1'b0, 1'b0);
            wr(4'h0, d);
            rd(4'h0, d & 16'h0707);
            route(d[0], d[2:1]);
            step(1'b0, 1'b1, 1'b1);
            step(1'b0, 1'b1, 1'b0);
            route(d[8], d[10:9]);
            rd(4'h1, 16'h0005);
            step(1'b0, 1'b1, 1'b1);
            step(1'b0, 1'b1, 1'b0);
            route(d[0], d[2:1]);
        end
        $display("select test done");
        step(1'b0, 1'b0, 1'b0);
        wr(4'h0, 16'h0505);
        step(1'b1, 1'b0, 1'b0);
        rd(4'h0, 16'h0);
        rd(4'h1, 16'h0002);
        wr(4'h0, 16'h0303);
        route(1'b0, 2'h0);
        step(1'b0, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b0);
        rd(4'h0, 16'h0505);
        route(1'b1, 2'h2);
        wr(4'h5, 16'hffff);
        rd(4'h5, 16'h0);
        rd(4'h0, 16'h0505);
        $display("mode test done");
        summarize();
    end
endmodule : tb_top
